// ==== hdl/fmce_device.sv ====
// Purpose: Device end; decodes commands from the serial link.
// Assumes: Link pins are asynchronous and are sampled by clk.
// Notes: Array data is read from an outside memory with one cycle latency.
`timescale 1ns/1ps
`default_nettype none
module fmce_device (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	// Serial link
	fmce_link_if.dev                           lnk,
	// Array read port
	output logic [fmce_pkg::ARRAY_AW-1:0]      array_addr,
	input  wire logic [7:0]                    array_data,
	// User side status
	input  wire logic                          otp_stall,
	output logic                               addr4_mode,
	output logic                               quad_mode,
	output logic                               power_down,
	output logic                               busy
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] sck_s;
	logic [2:0] cs_s;
	logic [2:0] di_s;
	logic       sck_q;
	logic       cs_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sck_s <= 3'h0;
			cs_s  <= 3'h7;
			di_s  <= 3'h0;
			sck_q <= 1'b0;
			cs_q  <= 1'b1;
		end else begin
			sck_s <= {sck_s[1:0], lnk.sclk};
			cs_s  <= {cs_s[1:0], lnk.cs_n};
			di_s  <= {di_s[1:0], lnk.io0};
			if (sck_s[2] == sck_s[1]) begin
				sck_q <= sck_s[2];
			end
			if (cs_s[2] == cs_s[1]) begin
				cs_q <= cs_s[2];
			end
		end
	end
	logic sel;
	logic sck_rise;
	logic sck_fall;
	logic cs_rise;
	logic cs_fall;
	assign sel      = !cs_q;
	assign sck_rise = (sck_s[2] == sck_s[1]) && sck_s[2] && !sck_q;
	assign sck_fall = (sck_s[2] == sck_s[1]) && !sck_s[2] && sck_q;
	assign cs_rise  = (cs_s[2] == cs_s[1]) && cs_s[2] && !cs_q;
	assign cs_fall  = (cs_s[2] == cs_s[1]) && !cs_s[2] && cs_q;
	// ----------------------------------------
	// Frame assembly
	// ----------------------------------------
	logic [7:0]  sh_q;
	logic [2:0]  bit_q;
	logic [5:0]  nb_q;
	logic [7:0]  byte_v;
	logic        byte_done;
	assign byte_v    = {sh_q[6:0], di_s[2]};
	assign byte_done = sck_rise && sel && (bit_q == 3'h7);
	always_ff @(posedge clk) begin
		if (sys_rst || cs_fall) begin
			sh_q  <= 8'h00;
			bit_q <= 3'h0;
			nb_q  <= 6'h00;
		end else if (sck_rise && sel) begin
			sh_q  <= byte_v;
			bit_q <= bit_q + 3'h1;
			if (bit_q == 3'h7 && nb_q != 6'h3F) begin
				nb_q <= nb_q + 6'h01;
			end
		end
	end
	logic [7:0]  op_q;
	logic [7:0]  sub_q;
	logic [7:0]  opt_q;
	logic [63:0] exp_q;
	logic [31:0] start_q;
	logic [31:0] stop_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			op_q    <= 8'h00;
			sub_q   <= 8'h00;
			opt_q   <= 8'h00;
			exp_q   <= 64'h0;
			start_q <= 32'h0;
			stop_q  <= 32'h0;
		end else if (byte_done) begin
			if (nb_q == 6'h00) begin
				op_q <= byte_v;
			end else if (nb_q == 6'h01) begin
				sub_q <= byte_v;
			end else if (nb_q == 6'h02) begin
				opt_q <= byte_v;
			end else if (nb_q <= 6'h0A) begin
				exp_q <= {byte_v, exp_q[63:8]};
			end else if (nb_q <= 6'h0E) begin
				start_q <= {byte_v, start_q[31:8]};
			end else if (nb_q <= 6'h12) begin
				stop_q <= {byte_v, stop_q[31:8]};
			end
		end
	end
	// ----------------------------------------
	// Command engine
	// ----------------------------------------
	fmce_pkg::fmce_dev_st_t st_q;
	logic [11:0]  cnt_q;
	logic         wren_latch_q;
	logic         fail_q;
	logic         prot_q;
	logic         addr4_q;
	logic         quad_q;
	logic         rst_en_q;
	logic [63:0]  crc_q;
	logic [63:0]  rb_buf_q;
	logic [31:0]  cur_q;
	logic [31:0]  last_q;
	logic [7:0]   otp_q [0:64];
	logic         idle;
	logic         wip;
	logic         exec;
	logic [5:0]   alen;
	logic         otp_commit;
	logic [63:0]  crc_nx;
	assign idle = (st_q == fmce_pkg::ST_IDLE);
	assign wip  = (st_q == fmce_pkg::ST_PROG) || (st_q == fmce_pkg::ST_CRC_RD) ||
		(st_q == fmce_pkg::ST_CRC_FOLD);
	assign exec = cs_rise && (bit_q == 3'h0) && (nb_q != 6'h00);
	assign alen = addr4_q ? fmce_pkg::ALEN4 : fmce_pkg::ALEN3;
	assign otp_commit = (st_q == fmce_pkg::ST_PROG) && !otp_stall &&
		(cnt_q >= fmce_pkg::OTP_PROG_LAST) && (cnt_q < fmce_pkg::OTP_TMO_LAST);
	// Data bits enter LSB first and the register starts at zero.
	function automatic logic [63:0] crc_byte(input logic [63:0] c, input logic [7:0] d);
		logic [63:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = {r[62:0], 1'b0} ^ ((r[63] ^ d[i]) ? fmce_pkg::CRC_POLY : 64'h0);
		end
		return r;
	endfunction
	assign crc_nx = crc_byte(crc_q, array_data);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q         <= fmce_pkg::ST_IDLE;
			cnt_q        <= 12'h000;
			wren_latch_q <= 1'b0;
			fail_q       <= 1'b0;
			prot_q       <= 1'b0;
			addr4_q      <= 1'b0;
			quad_q       <= 1'b0;
			rst_en_q     <= 1'b0;
			crc_q        <= 64'h0;
			rb_buf_q     <= 64'h0;
			cur_q        <= 32'h0;
			last_q       <= 32'h0;
		end else begin
			cnt_q <= cnt_q + 12'h001;
			case (st_q)
				fmce_pkg::ST_IDLE: begin
					cnt_q <= 12'h000;
					// Only the idle state takes the commands below, so entry during a write is refused.
					if (exec) begin
						case (op_q)
							fmce_pkg::OP_WREN: wren_latch_q <= 1'b1;
							fmce_pkg::OP_CLFSR: begin
								fail_q <= 1'b0;
								prot_q <= 1'b0;
							end
							fmce_pkg::OP_EN4B: addr4_q <= 1'b1;
							fmce_pkg::OP_EX4B: addr4_q <= 1'b0;
							fmce_pkg::OP_QUAD_EN: quad_q <= 1'b1;
							fmce_pkg::OP_QUAD_RST: quad_q <= 1'b0;
							fmce_pkg::OP_PD_ENTER: begin
								if (nb_q == 6'h01) begin
									st_q <= fmce_pkg::ST_PD_ENTER;
								end
							end
							fmce_pkg::OP_OTP_PROG: begin
								if (wren_latch_q && nb_q > alen + 6'h01) begin
									if (!otp_q[fmce_pkg::OTP_CTRL_IDX][fmce_pkg::OTP_LOCK_BIT]) begin
										fail_q <= 1'b1;
										prot_q <= 1'b1;
									end else begin
										st_q <= fmce_pkg::ST_PROG;
									end
								end
							end
							fmce_pkg::OP_CRC: begin
								if (sub_q == fmce_pkg::SUB_CRC && opt_q == fmce_pkg::OPT_ALL &&
									nb_q == fmce_pkg::LEN_CRC_ALL) begin
									cur_q    <= 32'h0;
									last_q   <= fmce_pkg::ARRAY_LAST;
									crc_q    <= 64'h0;
									rb_buf_q <= 64'h0;
									st_q     <= fmce_pkg::ST_CRC_RD;
								end else if (sub_q == fmce_pkg::SUB_CRC && opt_q == fmce_pkg::OPT_RANGE &&
									nb_q == fmce_pkg::LEN_CRC_RNG && start_q <= stop_q) begin
									cur_q    <= start_q;
									last_q   <= stop_q;
									crc_q    <= 64'h0;
									rb_buf_q <= 64'h0;
									st_q     <= fmce_pkg::ST_CRC_RD;
								end
							end
							default: begin
							end
						endcase
					end
				end
				fmce_pkg::ST_PROG: begin
					if (cnt_q >= fmce_pkg::OTP_TMO_LAST) begin
						wren_latch_q <= 1'b0;
						fail_q       <= 1'b1;
						st_q         <= fmce_pkg::ST_IDLE;
					end else if (otp_commit) begin
						wren_latch_q <= 1'b0;
						st_q         <= fmce_pkg::ST_IDLE;
					end
				end
				fmce_pkg::ST_CRC_RD: st_q <= fmce_pkg::ST_CRC_FOLD;
				fmce_pkg::ST_CRC_FOLD: begin
					crc_q <= crc_nx;
					if (cur_q == last_q) begin
						fail_q <= (crc_nx != exp_q);
						if (crc_nx != exp_q) begin
							rb_buf_q <= crc_nx;
						end
						st_q <= fmce_pkg::ST_IDLE;
					end else begin
						cur_q <= cur_q + 32'h1;
						st_q  <= fmce_pkg::ST_CRC_RD;
					end
				end
				fmce_pkg::ST_PD_ENTER: begin
					if (cnt_q >= fmce_pkg::PD_ENTRY_LAST) begin
						st_q <= fmce_pkg::ST_PD;
					end
				end
				fmce_pkg::ST_PD: begin
					cnt_q <= 12'h000;
					// Any extra clock leaves bit_q or nb_q off the one-byte count and voids it.
					if (exec && op_q == fmce_pkg::OP_PD_REL && nb_q == 6'h01) begin
						st_q <= fmce_pkg::ST_PD_EXIT;
					end
				end
				fmce_pkg::ST_PD_EXIT: begin
					if (cnt_q >= fmce_pkg::PD_REL_LAST) begin
						st_q <= fmce_pkg::ST_IDLE;
					end
				end
				fmce_pkg::ST_RECOV: begin
					if (cnt_q >= fmce_pkg::RECOV_LAST) begin
						st_q <= fmce_pkg::ST_IDLE;
					end
				end
				default: st_q <= fmce_pkg::ST_IDLE;
			endcase
			if (exec) begin
				rst_en_q <= (op_q == fmce_pkg::OP_RST_EN) && (nb_q == 6'h01);
			end
			// Software reset overrides every state, power-down included.
			if (exec && op_q == fmce_pkg::OP_RST && rst_en_q) begin
				st_q         <= fmce_pkg::ST_RECOV;
				cnt_q        <= 12'h000;
				wren_latch_q <= 1'b0;
				addr4_q      <= 1'b0;
				quad_q       <= 1'b0;
				rb_buf_q     <= 64'h0;
			end
		end
	end
	// ----------------------------------------
	// OTP staging and array
	// ----------------------------------------
	logic [7:0]  pend_q [0:64];
	logic [64:0] pmask_q;
	logic [6:0]  pw_q;
	always_ff @(posedge clk) begin
		if (sys_rst || (cs_fall && idle)) begin
			pmask_q <= 65'h0;
			pw_q    <= 7'h00;
		end else if (byte_done && idle && op_q == fmce_pkg::OP_OTP_PROG && nb_q != 6'h00) begin
			if (nb_q == alen) begin
				pw_q <= byte_v[6:0];
			end else if (nb_q > alen && pw_q <= fmce_pkg::OTP_CTRL_IDX) begin
				pend_q[pw_q]  <= byte_v;
				pmask_q[pw_q] <= 1'b1;
				pw_q          <= pw_q + 7'h01;
			end
		end
	end
	// Programming can only clear bits, so a cleared lock bit stays cleared until sys_rst.
	always_ff @(posedge clk) begin
		for (int i = 0; i <= 64; i++) begin
			if (sys_rst) begin
				otp_q[i] <= fmce_pkg::OTP_ERASED;
			end else if (otp_commit && pmask_q[i]) begin
				otp_q[i] <= otp_q[i] & pend_q[i];
			end
		end
	end
	// ----------------------------------------
	// Output shifter
	// ----------------------------------------
	logic [7:0] out_q;
	logic [7:0] out_nx;
	logic       do_q;
	logic [7:0] rsp_op;
	assign rsp_op = (nb_q == 6'h00) ? byte_v : op_q;
	always_comb begin
		out_nx = 8'h00;
		if (st_q != fmce_pkg::ST_PD && st_q != fmce_pkg::ST_PD_ENTER) begin
			if (rsp_op == fmce_pkg::OP_RDSR) begin
				out_nx = {6'h00, wren_latch_q, wip};
			end else if (rsp_op == fmce_pkg::OP_RDFSR) begin
				out_nx = {!wip, 2'h0, fail_q, 2'h0, prot_q, 1'b0};
			end else if (rsp_op == fmce_pkg::OP_RD_BUF && nb_q < 6'h08) begin
				out_nx = rb_buf_q[{nb_q[2:0], 3'h0} +: 8];
			end
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_q <= 8'h00;
			do_q  <= 1'b0;
		end else if (byte_done) begin
			out_q <= out_nx;
		end else if (sck_fall && sel) begin
			do_q  <= out_q[7];
			out_q <= {out_q[6:0], 1'b0};
		end
	end
	assign lnk.io1    = do_q;
	assign array_addr = cur_q[fmce_pkg::ARRAY_AW-1:0];
	assign addr4_mode = addr4_q;
	assign quad_mode  = quad_q;
	assign power_down = (st_q == fmce_pkg::ST_PD);
	assign busy       = wip || !idle;
endmodule
`default_nettype wire

// ==== include/fmce_pkg.sv ====
// Purpose: Shared constants and types of the flash misc command engine and its host.
// Assumes: Both ends run on one 40 MHz clk; the serial clock is made by the host.
package fmce_pkg;
	// ----------------------------------------
	// Opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_WREN      = 8'h06;
	localparam logic [7:0] OP_RDSR      = 8'h05;
	localparam logic [7:0] OP_RDFSR     = 8'h70;
	localparam logic [7:0] OP_CLFSR     = 8'h50;
	localparam logic [7:0] OP_OTP_PROG  = 8'h42;
	localparam logic [7:0] OP_EN4B      = 8'hB7;
	localparam logic [7:0] OP_EX4B      = 8'hE9;
	localparam logic [7:0] OP_PD_ENTER  = 8'hB9;
	localparam logic [7:0] OP_PD_REL    = 8'hAB;
	localparam logic [7:0] OP_QUAD_EN   = 8'h35;
	localparam logic [7:0] OP_QUAD_RST  = 8'hF5;
	localparam logic [7:0] OP_CRC       = 8'h9B;
	localparam logic [7:0] SUB_CRC      = 8'h27;
	localparam logic [7:0] OPT_ALL      = 8'hFF;
	localparam logic [7:0] OPT_RANGE    = 8'hFE;
	localparam logic [7:0] OP_RD_BUF    = 8'h96;
	localparam logic [7:0] OP_RST_EN    = 8'h66;
	localparam logic [7:0] OP_RST       = 8'h99;
	// ----------------------------------------
	// Frame lengths and layout
	// ----------------------------------------
	localparam logic [5:0] LEN_CRC_ALL  = 6'h0B;
	localparam logic [5:0] LEN_CRC_RNG  = 6'h13;
	localparam logic [5:0] ALEN3        = 6'h03;
	localparam logic [5:0] ALEN4        = 6'h04;
	localparam logic [6:0] OTP_CTRL_IDX = 7'h40;
	localparam int         OTP_LOCK_BIT = 0;
	localparam logic [7:0] OTP_ERASED   = 8'hFF;
	localparam int         ARRAY_AW     = 16;
	localparam logic [31:0] ARRAY_LAST  = 32'h0000FFFF;
	localparam logic [63:0] CRC_POLY    = 64'h42F0E1EBA9EA3693;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ        = 40;
	localparam int T_PD_ENTRY_NS  = 3000;
	localparam int T_PD_REL_NS    = 30000;
	localparam int T_RECOV_NS     = 2000;
	localparam int T_OTP_PROG_NS  = 20000;
	localparam int T_OTP_TMO_NS   = 100000;
	localparam int PD_ENTRY_CYC   = (T_PD_ENTRY_NS * CLK_MHZ + 999) / 1000;
	localparam int PD_REL_CYC     = (T_PD_REL_NS * CLK_MHZ + 999) / 1000;
	localparam int RECOV_CYC      = (T_RECOV_NS * CLK_MHZ + 999) / 1000;
	localparam int OTP_PROG_CYC   = (T_OTP_PROG_NS * CLK_MHZ + 999) / 1000;
	localparam int OTP_TMO_CYC    = (T_OTP_TMO_NS * CLK_MHZ) / 1000;
	localparam logic [11:0] PD_ENTRY_LAST = 12'(PD_ENTRY_CYC - 1);
	localparam logic [11:0] PD_REL_LAST   = 12'(PD_REL_CYC - 1);
	localparam logic [11:0] RECOV_LAST    = 12'(RECOV_CYC - 1);
	localparam logic [11:0] OTP_PROG_LAST = 12'(OTP_PROG_CYC - 1);
	localparam logic [11:0] OTP_TMO_LAST  = 12'(OTP_TMO_CYC - 1);
	localparam logic [3:0]  SCK_HALF_LAST = 4'h7;
	localparam logic [15:0] GAP_LAST      = 16'h0010;
	localparam logic [15:0] REL_GAP_LAST  = 16'(PD_REL_CYC + 16);
	// ----------------------------------------
	// Host register map
	// ----------------------------------------
	localparam logic [7:0] HR_TXBYTE = 8'h00;
	localparam logic [7:0] HR_CTRL   = 8'h04;
	localparam logic [7:0] HR_STATUS = 8'h08;
	localparam logic [7:0] HR_RXDATA = 8'h0C;
	localparam int         TX_DEPTH  = 32;
	// ----------------------------------------
	// States
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE     = 3'h0,
		ST_PROG     = 3'h1,
		ST_CRC_RD   = 3'h3,
		ST_CRC_FOLD = 3'h2,
		ST_PD_ENTER = 3'h6,
		ST_PD       = 3'h7,
		ST_PD_EXIT  = 3'h5,
		ST_RECOV    = 3'h4
	} fmce_dev_st_t;
	typedef enum logic [1:0] {
		HS_IDLE = 2'h0,
		HS_LOW  = 2'h1,
		HS_HIGH = 2'h3,
		HS_GAP  = 2'h2
	} fmce_host_st_t;
endpackage

// ==== include/fmce_link_if.sv ====
// Purpose: Serial link between host and device.
// Assumes: io0 carries host to device, io1 device to host.
// Notes: Single-lane lines only.
`timescale 1ns/1ps
`default_nettype none
interface fmce_link_if;
	logic cs_n;
	logic sclk;
	logic io0;
	logic io1;
	modport dev (input cs_n, input sclk, input io0, output io1);
	modport host (output cs_n, output sclk, output io0, input io1);
endinterface
`default_nettype wire

// ==== hdl/fmce_host.sv ====
// Purpose: Host end; sends frames built by software and gathers answers.
// Assumes: Serial clock made from clk by a divider of sixteen.
// Notes: Mode zero framing, MSB first on the line.
`timescale 1ns/1ps
`default_nettype none
module fmce_host (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Serial link
	fmce_link_if.host        lnk,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_we,
	input  wire logic        reg_re,
	output logic      [31:0] reg_rdata
);
	logic [2:0] mi_s;
	logic       mi_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mi_s <= 3'h0;
			mi_q <= 1'b0;
		end else begin
			mi_s <= {mi_s[1:0], lnk.io1};
			if (mi_s[2] == mi_s[1]) begin
				mi_q <= mi_s[2];
			end
		end
	end
	// ----------------------------------------
	// Frame engine
	// ----------------------------------------
	fmce_pkg::fmce_host_st_t st_q;
	logic [7:0]  tx_mem [0:fmce_pkg::TX_DEPTH-1];
	logic [5:0]  wp_q;
	logic [3:0]  ph_q;
	logic [15:0] gap_q;
	logic [15:0] bit_q;
	logic [15:0] nbits_q;
	logic [7:0]  last_op_q;
	logic [7:0]  rsh_q;
	logic [31:0] rx_q;
	logic        cs_q;
	logic        sck_q;
	logic        mo_q;
	logic        ready_seen_q;
	logic        refused_q;
	logic        start;
	logic        tx_bit;
	assign start  = reg_we && reg_addr == fmce_pkg::HR_CTRL && st_q == fmce_pkg::HS_IDLE && wp_q != 6'h00;
	assign tx_bit = (bit_q[15:3] < {7'h00, wp_q}) ? tx_mem[bit_q[7:3]][~bit_q[2:0]] : 1'b0;
	always_ff @(posedge clk) begin
		if (reg_we && reg_addr == fmce_pkg::HR_TXBYTE && st_q == fmce_pkg::HS_IDLE &&
			wp_q < 6'(fmce_pkg::TX_DEPTH)) begin
			tx_mem[wp_q[4:0]] <= reg_wdata[7:0];
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q         <= fmce_pkg::HS_IDLE;
			wp_q         <= 6'h00;
			ph_q         <= 4'h0;
			gap_q        <= 16'h0000;
			bit_q        <= 16'h0000;
			nbits_q      <= 16'h0000;
			last_op_q    <= 8'h00;
			rsh_q        <= 8'h00;
			rx_q         <= 32'h0;
			cs_q         <= 1'b1;
			sck_q        <= 1'b0;
			mo_q         <= 1'b0;
			ready_seen_q <= 1'b0;
			refused_q    <= 1'b0;
		end else begin
			case (st_q)
				fmce_pkg::HS_IDLE: begin
					if (reg_we && reg_addr == fmce_pkg::HR_TXBYTE && wp_q < 6'(fmce_pkg::TX_DEPTH)) begin
						wp_q <= wp_q + 6'h01;
					end
					if (start) begin
						refused_q <= 1'b0;
						if ((tx_mem[0] == fmce_pkg::OP_QUAD_EN || tx_mem[0] == fmce_pkg::OP_QUAD_RST) &&
							last_op_q == fmce_pkg::OP_WREN) begin
							refused_q <= 1'b1;
							wp_q      <= 6'h00;
						end else begin
							// Power-down entry is cut after its eighth bit whatever was queued.
							nbits_q      <= (tx_mem[0] == fmce_pkg::OP_PD_ENTER) ? 16'h0008 :
								{4'h0, ({3'h0, wp_q} + reg_wdata[8:0]), 3'h0};
							last_op_q    <= tx_mem[0];
							ready_seen_q <= 1'b0;
							bit_q        <= 16'h0000;
							ph_q         <= 4'h0;
							cs_q         <= 1'b0;
							st_q         <= fmce_pkg::HS_LOW;
						end
					end
				end
				fmce_pkg::HS_LOW: begin
					ph_q <= ph_q + 4'h1;
					if (ph_q == 4'h0) begin
						mo_q <= tx_bit;
					end
					if (ph_q == fmce_pkg::SCK_HALF_LAST) begin
						ph_q  <= 4'h0;
						sck_q <= 1'b1;
						st_q  <= fmce_pkg::HS_HIGH;
					end
				end
				fmce_pkg::HS_HIGH: begin
					ph_q <= ph_q + 4'h1;
					if (ph_q == fmce_pkg::SCK_HALF_LAST) begin
						ph_q  <= 4'h0;
						sck_q <= 1'b0;
						rsh_q <= {rsh_q[6:0], mi_q};
						bit_q <= bit_q + 16'h0001;
						if (bit_q[2:0] == 3'h7) begin
							rx_q <= {rx_q[23:0], rsh_q[6:0], mi_q};
							if (last_op_q == fmce_pkg::OP_RDFSR && rsh_q[6] && bit_q[15:3] >= {7'h00, wp_q}) begin
								ready_seen_q <= 1'b1;
							end
						end
						if (bit_q + 16'h0001 >= nbits_q) begin
							cs_q  <= 1'b1;
							gap_q <= 16'h0000;
							st_q  <= fmce_pkg::HS_GAP;
						end else begin
							st_q <= fmce_pkg::HS_LOW;
						end
					end
				end
				fmce_pkg::HS_GAP: begin
					gap_q <= gap_q + 16'h0001;
					mo_q  <= 1'b0;
					// After a release the select stays high for the whole release delay.
					if (gap_q >= ((last_op_q == fmce_pkg::OP_PD_REL) ? fmce_pkg::REL_GAP_LAST :
						fmce_pkg::GAP_LAST)) begin
						wp_q <= 6'h00;
						st_q <= fmce_pkg::HS_IDLE;
					end
				end
				default: st_q <= fmce_pkg::HS_IDLE;
			endcase
		end
	end
	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst || !reg_re) begin
			reg_rdata <= 32'h0;
		end else if (reg_addr == fmce_pkg::HR_STATUS) begin
			reg_rdata <= {29'h0, refused_q, ready_seen_q, st_q != fmce_pkg::HS_IDLE};
		end else if (reg_addr == fmce_pkg::HR_RXDATA) begin
			reg_rdata <= rx_q;
		end else begin
			reg_rdata <= 32'h0;
		end
	end
	assign lnk.cs_n = cs_q;
	assign lnk.sclk = sck_q;
	assign lnk.io0  = mo_q;
endmodule
`default_nettype wire

// ==== test/fmce_link_asserts.sv ====
// Purpose: Link framing and device mode checks.
// Assumes: One clk domain for host and device.
// Notes: Sees the link lines and device status.
`timescale 1ns/1ps
`default_nettype none
module fmce_link_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Link and status
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic io0,
	input wire logic io1,
	input wire logic power_down,
	input wire logic busy,
	input wire logic addr4_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_sclk_idle_out: assert property (cs_n && $past(cs_n) |-> !sclk) else $error("sclk outside frame");
	chk_rst_idle_lvl: assert property ($fell(sys_rst) |-> cs_n && !sclk && !io1) else $error("bad idle");
	chk_sclk_high_len: assert property ($rose(sclk) |-> sclk[*8]) else $error("short sclk high");
	chk_io0_hold: assert property (sclk && $past(sclk) |-> $stable(io0)) else $error("io0 moved");
	chk_pd_entry_wait: assert property ($rose(power_down) |-> $past(busy, 100)) else $error("fast entry");
	chk_pd_busy_lvl: assert property (power_down |-> busy) else $error("pd not busy");
	chk_pd_exit_cs: assert property ($fell(power_down) |-> cs_n) else $error("select low");
	chk_mode_at_idle: assert property ($changed(addr4_mode) |-> cs_n) else $error("mode in frame");
	cover property ($rose(power_down));
	cover property ($fell(addr4_mode));
	cover property ($fell(busy) && !power_down);
endmodule
`default_nettype wire

// ==== test/flash_misc_command_engine_bench.sv ====
// Purpose: End to end bench of host and device.
// Assumes: Software builds frames through the host register port.
// Notes: Array modelled by sixteen random bytes; range checks only, to keep the run short.
`timescale 1ns/1ps
`default_nettype none
module flash_misc_command_engine_bench;
	// ----
	// Wiring
	// ----
	logic clk = 0, sys_rst = 1, reg_we = 0, reg_re = 0, otp_stall = 0, re_q = 0;
	logic [7:0] reg_addr = 0, array_data = 0, mem [16];
	logic [31:0] reg_wdata = 0, reg_rdata, got;
	logic [15:0] array_addr;
	logic addr4_mode, quad_mode, power_down, busy;
	logic [63:0] x, e, exp_q [$];
	logic [7:0] bq [$];
	int n_errors = 0, n_compared = 0;
	fmce_link_if lnk ();
	fmce_device u_fmce_device (.clk(clk), .sys_rst(sys_rst), .lnk(lnk.dev), .array_addr(array_addr),
		.array_data(array_data), .otp_stall(otp_stall), .addr4_mode(addr4_mode), .quad_mode(quad_mode),
		.power_down(power_down), .busy(busy));
	fmce_host u_fmce_host (.clk(clk), .sys_rst(sys_rst), .lnk(lnk.host), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
	fmce_link_asserts u_fmce_link_asserts (.clk(clk), .sys_rst(sys_rst), .cs_n(lnk.cs_n), .sclk(lnk.sclk),
		.io0(lnk.io0), .io1(lnk.io1), .power_down(power_down), .busy(busy), .addr4_mode(addr4_mode));
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) array_data <= mem[array_addr[3:0]];
	// ----
	// Tasks
	// ----
	task automatic give_verdict;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] v);
		n_compared++;
		if (g !== v) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, v);
		end
	endtask
	// A read carries its expected value on wdata, which the host ignores on reads.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= w;
		reg_re <= !w;
		if (!w)
			exp_q.push_back({m, d});
		@(posedge clk);
		reg_we <= 0;
		reg_re <= 0;
		#1 got = reg_rdata;
	endtask
	task automatic cmd(input logic [7:0] b, input int n);
		int k;
		bq.push_back(b);
		foreach (bq[i])
			bus(1, fmce_pkg::HR_TXBYTE, {24'h0, bq[i]}, 0);
		bus(1, fmce_pkg::HR_CTRL, 32'(n), 0);
		bq.delete();
		k = 0;
		do begin
			bus(0, fmce_pkg::HR_STATUS, 0, 0);
			k++;
		end while (got[0] !== 1'b0 && k < 9000);
		if (k >= 9000) begin
			n_errors++;
			give_verdict();
		end
	endtask
	task automatic ask(input logic [7:0] op, input int n, input logic [31:0] v, input logic [31:0] m);
		cmd(op, n);
		bus(0, fmce_pkg::HR_RXDATA, v, m);
	endtask
	task automatic prog(input logic [7:0] a, input logic [7:0] d);
		cmd(fmce_pkg::OP_WREN, 0);
		bq = '{8'h42, 8'h00, 8'h00, a};
		cmd(d, 0);
		// The host frame ends long before the self-timed program does, so wait it out.
		repeat (900) @(posedge clk);
	endtask
	task automatic crc_run(input logic [63:0] v);
		bq = '{8'h9B, 8'h27, 8'hFE};
		for (int i = 0; i < 8; i++)
			bq.push_back(v[8*i +: 8]);
		for (int i = 0; i < 7; i++)
			bq.push_back(i == 4 ? 8'h0F : 8'h00);
		cmd(8'h00, 0);
	endtask
	function automatic logic [63:0] crc_of(input int n);
		logic [63:0] c;
		c = 0;
		for (int a = 0; a < n; a++)
			for (int i = 0; i < 8; i++)
				c = {c[62:0], 1'b0} ^ ((c[63] ^ mem[a][i]) ? fmce_pkg::CRC_POLY : 64'h0);
		return c;
	endfunction
	// ----
	// Checking and stimulus
	// ----
	always @(posedge clk) begin
		re_q <= reg_re;
		if (re_q) begin
			e = exp_q.pop_front();
			if (e[63:32] != 0)
				cmp(reg_rdata & e[63:32], e[31:0] & e[63:32]);
		end
	end
	initial begin
		#2250000;
		n_errors++;
		give_verdict();
	end
	initial begin
		void'($urandom(79493));
		foreach (mem[i])
			mem[i] = 8'($urandom());
		repeat (16) @(posedge clk);
		sys_rst <= 0;
		repeat (4) @(posedge clk);
		bus(0, fmce_pkg::HR_STATUS, 0, '1);
		bus(0, 8'h10, 0, '1);
		cmd(fmce_pkg::OP_EN4B, 0);
		cmp(32'(addr4_mode), 32'h1);
		cmd(fmce_pkg::OP_EX4B, 0);
		cmp(32'(addr4_mode), 32'h0);
		cmd(fmce_pkg::OP_QUAD_EN, 0);
		cmp(32'(quad_mode), 32'h1);
		cmd(fmce_pkg::OP_QUAD_RST, 0);
		cmp(32'(quad_mode), 32'h0);
		cmd(fmce_pkg::OP_WREN, 0);
		cmd(fmce_pkg::OP_QUAD_EN, 0);
		bus(0, fmce_pkg::HR_STATUS, 32'h4, 32'h4);
		cmp(32'(quad_mode), 32'h0);
		$display("modes done");
		@(posedge clk);
		otp_stall <= 1;
		prog(8'h05, 8'($urandom()));
		cmd(fmce_pkg::OP_PD_ENTER, 0);
		repeat (200) @(posedge clk);
		cmp(32'(power_down), 32'h0);
		repeat (3000) @(posedge clk);
		otp_stall <= 0;
		ask(fmce_pkg::OP_RDFSR, 1, 32'h90, 32'hFF);
		ask(fmce_pkg::OP_RDSR, 1, 32'h00, 32'hFF);
		cmd(fmce_pkg::OP_CLFSR, 0);
		prog(8'h01, 8'($urandom()));
		ask(fmce_pkg::OP_RDSR, 1, 32'h00, 32'hFF);
		ask(fmce_pkg::OP_RDFSR, 1, 32'h80, 32'hFF);
		bus(0, fmce_pkg::HR_STATUS, 32'h2, 32'h2);
		prog(8'h40, 8'hFE);
		prog(8'h00, 8'h00);
		ask(fmce_pkg::OP_RDFSR, 1, 32'h92, 32'hFF);
		ask(fmce_pkg::OP_RDSR, 1, 32'h02, 32'hFF);
		$display("otp done");
		cmd(fmce_pkg::OP_CLFSR, 0);
		x = crc_of(16);
		crc_run(~x);
		ask(fmce_pkg::OP_RDFSR, 1, 32'h90, 32'hFF);
		ask(fmce_pkg::OP_RD_BUF, 9, {x[47:40], x[55:48], x[63:56], 8'h00}, '1);
		crc_run(x);
		ask(fmce_pkg::OP_RDFSR, 1, 32'h80, 32'hFF);
		ask(fmce_pkg::OP_RD_BUF, 9, 0, '1);
		$display("crc done");
		cmd(fmce_pkg::OP_PD_ENTER, 0);
		repeat (130) @(posedge clk);
		cmp(32'(power_down), 32'h1);
		cmd(fmce_pkg::OP_EN4B, 0);
		cmp(32'(addr4_mode), 32'h0);
		bq = '{fmce_pkg::OP_PD_REL};
		cmd(8'h00, 0);
		cmp(32'(power_down), 32'h1);
		cmd(fmce_pkg::OP_PD_REL, 0);
		cmp(32'(power_down), 32'h0);
		cmp(32'(busy), 32'h0);
		cmd(fmce_pkg::OP_PD_ENTER, 0);
		repeat (130) @(posedge clk);
		cmd(fmce_pkg::OP_RST_EN, 0);
		cmd(fmce_pkg::OP_RST, 0);
		repeat (100) @(posedge clk);
		cmp(32'(power_down), 32'h0);
		$display("power down done");
		give_verdict();
	end
endmodule
`default_nettype wire
